//--- ulmsd_pkg.sv
/*
 * shared constants, carrier structs and state codes for the serial port
 * status and baud divisor block.
 * assumes a byte-wide register set on word-aligned bus addresses.
 */
`default_nettype none
package ulmsd_pkg;
	// register indices; byte address is four times the index
	localparam logic [2:0] IDX_DIV_LO    = 3'h0;
	localparam logic [2:0] IDX_MODEM_ST  = 3'h0;
	localparam logic [2:0] IDX_DIV_HI    = 3'h1;
	localparam logic [2:0] IDX_RX_DATA   = 3'h2;
	localparam logic [2:0] IDX_LINE_CTL  = 3'h3;
	localparam logic [2:0] IDX_MODEM_CTL = 3'h4;
	localparam logic [2:0] IDX_LINE_ST   = 3'h5;
	// reset values
	localparam logic [7:0] DIV_RESET       = 8'h00;
	localparam logic [7:0] LINE_ST_RESET   = 8'h00;
	localparam logic [7:0] LINE_CTL_RESET  = 8'h03;
	localparam logic [7:0] MODEM_CTL_RESET = 8'h00;
	// line status bit positions
	localparam int LS_ERR = 7;
	localparam int LS_TXIDLE = 6;
	localparam int LS_TXEMPTY = 5;
	localparam int LS_BRK = 4;
	localparam int LS_FRAME = 3;
	localparam int LS_PARITY = 2;
	localparam int LS_OE = 1;
	localparam int LS_RXRDY = 0;
	// modem status bit positions
	localparam int MS_RI = 6;
	localparam int MS_RINGEDGE = 2;
	// buffering
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 8;

	// line control: divisor access, parity, stop length, char length
	typedef struct packed {
		logic       divAccess;
		logic [1:0] rsvd;
		logic       evenParity;
		logic       parityEn;
		logic       stopLong;
		logic [1:0] charLen;
	} ulmsd_line_ctl_t;

	// modem control: loopback and the four modem outputs
	typedef struct packed {
		logic [2:0] rsvd;
		logic       loopback;
		logic       auxTwo;
		logic       auxOne;
		logic       rts;
		logic       dtr;
	} ulmsd_modem_ctl_t;

	typedef enum logic [4:0] {
		SER_IDLE  = 5'b00001,
		SER_START = 5'b00010,
		SER_DATA  = 5'b00100,
		SER_PAR   = 5'b01000,
		SER_STOP  = 5'b10000
	} ulmsd_ser_state_t;
endpackage
`default_nettype wire

//--- ulmsd_uart.sv
/*
 * fifo plus the serial port core: line and modem status, baud divisor,
 * transmitter and receiver, avalon-mm slave with waitrequest.
 * assumes all inputs synchronous to sys_clk and one clock domain.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// simple synchronous fifo, valid/ready on both sides
module ulmsd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_q;
	logic [AW:0]      rdPtr_q;
	wire              doPush = inValid & inReady;
	wire              doPop  = outValid & outReady;

	// full when pointers differ only in the wrap bit
	assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {AW{1'b0}}};
	assign outValid = wrPtr_q != rdPtr_q;
	assign outData  = mem[rdPtr_q[AW-1:0]];

	always_ff @(posedge sys_clk) begin
		if (doPush) mem[wrPtr_q[AW-1:0]] <= inData;
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_q + (AW+1)'(doPush);
			rdPtr_q <= rdPtr_q + (AW+1)'(doPop);
		end
	end
endmodule // ulmsd_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// RULE1 - line status bit 7 reads 1 while parity, framing or break pending
// RULE2 - bit 6 set only with transmit fifo and shifter empty; fifo write clears
// RULE3 - bit 5 reads 1 while transmit fifo empty, 0 once written
// RULE4 - bit 4 set when whole received character incl. stop bit is zero
// RULE5 - bit 3 set when received character lacks a valid stop bit
// RULE6 - bit 2 set when received character fails configured parity check
// RULE7 - bit 1 set when a character arrives with receive storage full
// RULE8 - bit 0 follows receive fifo: 1 while not empty
// RULE9 - line status read clears bits 7 and 4..1; transmit flags unaffected
// RULE10 - normal mode: modem status 7..4 are inverted carrier, ring, ready, clear
// RULE11 - loopback: modem status 7..4 come from aux two, aux one, dtr, rts
// RULE12 - modem status bit 2 set when ring input goes low to high
// RULE13 - 16-bit divisor as two read-write bytes at 0x00/0x01, reset zero
// RULE14 - loopback holds serial output at 1, transmitter feeds receiver inside
// RULE15 - parity enabled: append on transmit, check on receive, odd or even
// RULE16 - 2-bit character length: 00..11 select 5..8 data bits
// RULE17 - carrier, ready and clear deltas set on change, cleared by status read
// RULE18 - bit time is divisor clocks; timing restarts on divisor byte write
// RULE19 - line status reads 0x00 after reset, then transmit flags track state
module ulmsd_uart
	import ulmsd_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [4:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        rxd,
	output logic             txd,
	input  wire logic        dcdN,
	input  wire logic        riN,
	input  wire logic        dsrN,
	input  wire logic        ctsN,
	output logic             dtrN,
	output logic             rtsN,
	output logic             auxOneN,
	output logic             auxTwoN
);
	// parity of the active data bits; even selects total count of ones even
	function automatic logic parityOf(logic [7:0] d, logic [1:0] len, logic even);
		logic [7:0] mask;
		mask = 8'hff >> (2'd3 - len);
		return (^(d & mask)) ^ ~even;
	endfunction

	// bus side registers
	logic             waitReq_q;
	logic [7:0]       rdByte_q;
	logic             rxTake_q;
	logic [7:0]       divLo_q;
	logic [7:0]       divHi_q;
	ulmsd_line_ctl_t  lineCtl_q;
	ulmsd_modem_ctl_t modemCtl_q;
	// status
	logic             brk_q, frame_q, par_q, ovr_q;
	logic             txIdleFlag_q, txEmptyFlag_q;
	logic [3:0]       msPrev_q;
	logic             msPrimed_q;
	logic             dCarrier_q, dReady_q, dClear_q, ringEdge_q;
	// serial engines
	ulmsd_ser_state_t txState_q, rxState_q;
	logic [16:0]      txCnt_q, rxCnt_q;
	logic [7:0]       txShift_q, txHold_q, rxShift_q;
	logic [2:0]       txBit_q, rxBit_q;
	logic             txLine_q, serPrev_q, rxZero_q, rxPar_q;
	logic             txd_q, dtrN_q, rtsN_q, auxOneN_q, auxTwoN_q;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	wire [2:0]  idx      = address[4:2];
	wire        req      = read | write;
	wire        dlab     = lineCtl_q.divAccess;
	wire        txWrSel  = write & (idx == IDX_DIV_LO) & ~dlab;
	wire        txInRdy;
	wire        stall    = txWrSel & ~txInRdy;
	wire        acc      = req & ~waitReq_q;
	wire        sample   = req & waitReq_q & ~stall;
	wire        divWr    = acc & write & dlab & ((idx == IDX_DIV_LO) | (idx == IDX_DIV_HI));
	wire        lsrRd    = acc & read & (idx == IDX_LINE_ST);
	wire        msrRd    = acc & read & (idx == IDX_MODEM_ST) & ~dlab;
	wire [15:0] divisor  = {divHi_q, divLo_q};
	wire        baudOn   = divisor != 16'h0000;
	wire [16:0] bitLen   = {1'b0, divisor};
	wire [16:0] halfLen  = (divisor > 16'h0001) ? {2'b00, divisor[15:1]} : 17'h00001;
	wire [3:0]  nBits    = 4'd5 + {2'b00, lineCtl_q.charLen}; // [RULE16]

	// receive fifo handshakes
	wire       rxInRdy, rxOutValid;
	wire [7:0] rxOutData;
	wire       rxPop = acc & read & (idx == IDX_RX_DATA) & rxTake_q;

	// modem levels: pins inverted, or internal controls in loopback
	wire [3:0] msLevel = modemCtl_q.loopback ?
		{modemCtl_q.auxTwo, modemCtl_q.auxOne, modemCtl_q.dtr, modemCtl_q.rts} : // [RULE11]
		~{dcdN, riN, dsrN, ctsN}; // [RULE10]
	wire [3:0] msChg   = msPrimed_q ? (msLevel ^ msPrev_q) : 4'h0;
	wire       ringSet = msPrimed_q & msPrev_q[2] & ~msLevel[2]; // [RULE12]

	// line status and modem status as presented
	wire [7:0] lsrByte = {brk_q | frame_q | par_q, // [RULE1]
		txIdleFlag_q, txEmptyFlag_q, brk_q, frame_q, par_q, ovr_q, rxOutValid}; // [RULE8]
	wire [7:0] msrByte = {msLevel, dCarrier_q, ringEdge_q, dReady_q, dClear_q};
	wire [7:0] rdMux   =
		(idx == IDX_DIV_LO  &  dlab) ? divLo_q :
		(idx == IDX_MODEM_ST & ~dlab) ? msrByte :
		(idx == IDX_DIV_HI  &  dlab) ? divHi_q :
		(idx == IDX_RX_DATA)   ? (rxOutValid ? rxOutData : 8'h00) :
		(idx == IDX_LINE_CTL)  ? lineCtl_q :
		(idx == IDX_MODEM_CTL) ? modemCtl_q :
		(idx == IDX_LINE_ST)   ? lsrByte : 8'h00;

	// clear masks come from the byte actually returned, so a new event wins
	wire [7:0] lsrClr = lsrRd ? rdByte_q : 8'h00; // [RULE9]
	wire [7:0] msrClr = msrRd ? rdByte_q : 8'h00; // [RULE17]

	////////////////////////////////////////////////////////////////////////
	// bus handshake: one wait cycle, held while transmit fifo full
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			waitReq_q <= 1'b1;
			rdByte_q  <= 8'h00;
			rxTake_q  <= 1'b0;
		end else begin
			waitReq_q <= ~sample;
			if (sample) begin
				rdByte_q <= read ? rdMux : 8'h00;
				rxTake_q <= rxOutValid;
			end
		end
	end

	// control registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			divLo_q    <= DIV_RESET; // [RULE13]
			divHi_q    <= DIV_RESET;
			lineCtl_q  <= LINE_CTL_RESET;
			modemCtl_q <= MODEM_CTL_RESET;
		end else if (acc & write) begin
			if (dlab & idx == IDX_DIV_LO) divLo_q <= writedata[7:0]; // [RULE13]
			if (dlab & idx == IDX_DIV_HI) divHi_q <= writedata[7:0];
			if (idx == IDX_LINE_CTL) lineCtl_q <= writedata[7:0];
			if (idx == IDX_MODEM_CTL) modemCtl_q <= writedata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// transmit path
	wire       txOutValid;
	wire [7:0] txOutData;
	wire       txPop   = txState_q == SER_IDLE && txOutValid && baudOn;
	wire [16:0] stopLen = !lineCtl_q.stopLong ? bitLen :
		(lineCtl_q.charLen == 2'b00) ? bitLen + {1'b0, divisor[15:1]} : {divisor, 1'b0};
	wire       txDone  = txCnt_q + 17'd1 >= ((txState_q == SER_STOP) ? stopLen : bitLen);
	wire       txLast  = {1'b0, txBit_q} == nBits - 4'd1;

	ulmsd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) txFifo (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.inValid  (acc & txWrSel),
		.inReady  (txInRdy),
		.inData   (writedata[7:0]),
		.outValid (txOutValid),
		.outReady (txPop),
		.outData  (txOutData)
	);

	// transmitter state machine, timing restarts on divisor writes
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txState_q <= SER_IDLE;
			txCnt_q   <= '0;
			txShift_q <= 8'h00;
			txHold_q  <= 8'h00;
			txBit_q   <= 3'h0;
			txLine_q  <= 1'b1;
		end else if (divWr) begin
			txCnt_q <= '0; // [RULE18]
		end else begin
			txCnt_q <= (txState_q == SER_IDLE || txDone) ? 17'd0 : txCnt_q + 17'd1;
			unique case (txState_q)
				SER_IDLE: if (txPop) begin
					txShift_q <= txOutData;
					txHold_q  <= txOutData;
					txLine_q  <= 1'b0;
					txState_q <= SER_START;
				end
				SER_START: if (txDone) begin
					txLine_q  <= txShift_q[0];
					txShift_q <= txShift_q >> 1;
					txBit_q   <= 3'h0;
					txState_q <= SER_DATA;
				end
				SER_DATA: if (txDone) begin
					if (txLast && lineCtl_q.parityEn) begin
						txLine_q  <= parityOf(txHold_q, lineCtl_q.charLen,
							lineCtl_q.evenParity); // [RULE15]
						txState_q <= SER_PAR;
					end else if (txLast) begin
						txLine_q  <= 1'b1;
						txState_q <= SER_STOP;
					end else begin
						txLine_q  <= txShift_q[0];
						txShift_q <= txShift_q >> 1;
						txBit_q   <= txBit_q + 3'd1;
					end
				end
				SER_PAR: if (txDone) begin
					txLine_q  <= 1'b1;
					txState_q <= SER_STOP;
				end
				SER_STOP: if (txDone) txState_q <= SER_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// receive path; loopback takes the transmit line internally
	wire serIn   = modemCtl_q.loopback ? txLine_q : rxd; // [RULE14]
	wire rxDone  = rxCnt_q + 17'd1 >= ((rxState_q == SER_START) ? halfLen : bitLen);
	wire rxLast  = {1'b0, rxBit_q} == nBits - 4'd1;
	wire rxFinal = rxState_q == SER_STOP && rxDone;
	wire [7:0] rxWord = rxShift_q >> (2'd3 - lineCtl_q.charLen);
	wire rxBrk   = rxFinal & rxZero_q & ~serIn; // [RULE4]
	wire rxFrm   = rxFinal & ~serIn; // [RULE5]
	wire rxPerr  = rxFinal & lineCtl_q.parityEn &
		(rxPar_q != parityOf(rxWord, lineCtl_q.charLen, lineCtl_q.evenParity)); // [RULE6]
	wire rxOvr   = rxFinal & ~rxInRdy; // [RULE7]

	ulmsd_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rxFifo (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.inValid  (rxFinal),
		.inReady  (rxInRdy),
		.inData   (rxWord),
		.outValid (rxOutValid),
		.outReady (rxPop),
		.outData  (rxOutData)
	);

	// receiver: start on falling edge, sample mid-bit
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rxState_q <= SER_IDLE;
			rxCnt_q   <= '0;
			rxShift_q <= 8'h00;
			rxBit_q   <= 3'h0;
			rxZero_q  <= 1'b0;
			rxPar_q   <= 1'b0;
			serPrev_q <= 1'b1;
		end else if (divWr) begin
			rxCnt_q   <= '0; // [RULE18]
			rxState_q <= SER_IDLE;
			serPrev_q <= serIn;
		end else begin
			serPrev_q <= serIn;
			rxCnt_q   <= (rxState_q == SER_IDLE || rxDone) ? 17'd0 : rxCnt_q + 17'd1;
			unique case (rxState_q)
				SER_IDLE: if (baudOn && serPrev_q && !serIn) rxState_q <= SER_START;
				SER_START: if (rxDone) begin
					rxState_q <= serIn ? SER_IDLE : SER_DATA;
					rxBit_q   <= 3'h0;
					rxZero_q  <= 1'b1;
				end
				SER_DATA: if (rxDone) begin
					rxShift_q <= {serIn, rxShift_q[7:1]};
					rxZero_q  <= rxZero_q & ~serIn;
					rxBit_q   <= rxBit_q + 3'd1;
					if (rxLast) rxState_q <= lineCtl_q.parityEn ? SER_PAR : SER_STOP;
				end
				SER_PAR: if (rxDone) begin
					rxPar_q   <= serIn;
					rxZero_q  <= rxZero_q & ~serIn;
					rxState_q <= SER_STOP;
				end
				SER_STOP: if (rxDone) rxState_q <= SER_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky status: set wins over a read clear
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			brk_q         <= LINE_ST_RESET[LS_BRK]; // [RULE19]
			frame_q       <= LINE_ST_RESET[LS_FRAME];
			par_q         <= LINE_ST_RESET[LS_PARITY];
			ovr_q         <= LINE_ST_RESET[LS_OE];
			txIdleFlag_q  <= LINE_ST_RESET[LS_TXIDLE];
			txEmptyFlag_q <= LINE_ST_RESET[LS_TXEMPTY];
		end else begin
			brk_q   <= (brk_q & ~lsrClr[LS_BRK]) | rxBrk; // [RULE9]
			frame_q <= (frame_q & ~lsrClr[LS_FRAME]) | rxFrm;
			par_q   <= (par_q & ~lsrClr[LS_PARITY]) | rxPerr;
			ovr_q   <= (ovr_q & ~lsrClr[LS_OE]) | rxOvr;
			txEmptyFlag_q <= ~txOutValid & ~(acc & txWrSel); // [RULE3]
			txIdleFlag_q  <= ~txOutValid & ~(acc & txWrSel) & ~txPop &
				(txState_q == SER_IDLE); // [RULE2]
		end
	end

	// modem deltas and ring trailing edge
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			msPrev_q   <= 4'h0;
			msPrimed_q <= 1'b0;
			dCarrier_q <= 1'b0;
			ringEdge_q <= 1'b0;
			dReady_q   <= 1'b0;
			dClear_q   <= 1'b0;
		end else begin
			msPrev_q   <= msLevel;
			msPrimed_q <= 1'b1;
			dCarrier_q <= (dCarrier_q & ~msrClr[3]) | msChg[3]; // [RULE17]
			ringEdge_q <= (ringEdge_q & ~msrClr[MS_RINGEDGE]) | ringSet; // [RULE12]
			dReady_q   <= (dReady_q & ~msrClr[1]) | msChg[1];
			dClear_q   <= (dClear_q & ~msrClr[0]) | msChg[0];
		end
	end

	// output pins, all registered; modem outputs inactive in loopback
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			txd_q     <= 1'b1;
			dtrN_q    <= 1'b1;
			rtsN_q    <= 1'b1;
			auxOneN_q <= 1'b1;
			auxTwoN_q <= 1'b1;
		end else begin
			txd_q     <= modemCtl_q.loopback | txLine_q; // [RULE14]
			dtrN_q    <= modemCtl_q.loopback | ~modemCtl_q.dtr;
			rtsN_q    <= modemCtl_q.loopback | ~modemCtl_q.rts;
			auxOneN_q <= modemCtl_q.loopback | ~modemCtl_q.auxOne;
			auxTwoN_q <= modemCtl_q.loopback | ~modemCtl_q.auxTwo;
		end
	end

	assign readdata    = {24'h000000, rdByte_q};
	assign waitrequest = waitReq_q;
	assign txd         = txd_q;
	assign dtrN        = dtrN_q;
	assign rtsN        = rtsN_q;
	assign auxOneN     = auxOneN_q;
	assign auxTwoN     = auxTwoN_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_errSummary;
		@(posedge sys_clk) disable iff (!nrst)
		sample & read & (idx == IDX_LINE_ST) |=>
			rdByte_q[LS_ERR] == (rdByte_q[LS_BRK] | rdByte_q[LS_FRAME] | rdByte_q[LS_PARITY]);
	endproperty
	a_errSummary: assert property (p_errSummary) else $error("error summary wrong"); // [RULE1]

	property p_idleImpliesEmpty;
		@(posedge sys_clk) disable iff (!nrst)
		txIdleFlag_q |-> txEmptyFlag_q && txState_q == SER_IDLE;
	endproperty
	a_idleImpliesEmpty: assert property (p_idleImpliesEmpty) else $error("idle early"); // [RULE2]

	property p_emptyDrops;
		@(posedge sys_clk) disable iff (!nrst)
		acc & txWrSel |=> !txEmptyFlag_q;
	endproperty
	a_emptyDrops: assert property (p_emptyDrops) else $error("empty flag kept on write"); // [RULE3]

	property p_overrun;
		@(posedge sys_clk) disable iff (!nrst)
		rxFinal & !rxInRdy |=> ovr_q;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost"); // [RULE7]

	property p_readyFollowsFifo;
		@(posedge sys_clk) disable iff (!nrst)
		sample & read & (idx == IDX_LINE_ST) |=> rdByte_q[LS_RXRDY] == $past(rxOutValid);
	endproperty
	a_readyFollowsFifo: assert property (p_readyFollowsFifo) else $error("ready bit"); // [RULE8]

	property p_lsrClears;
		@(posedge sys_clk) disable iff (!nrst)
		lsrRd & !rxFinal |=>
			({brk_q, frame_q, par_q, ovr_q} & $past(rdByte_q[LS_BRK:LS_OE])) == 4'h0;
	endproperty
	a_lsrClears: assert property (p_lsrClears) else $error("status read did not clear"); // [RULE9]

	property p_modemNormal;
		@(posedge sys_clk) disable iff (!nrst)
		!modemCtl_q.loopback |-> msrByte[7:4] == ~{dcdN, riN, dsrN, ctsN};
	endproperty
	a_modemNormal: assert property (p_modemNormal) else $error("modem levels wrong"); // [RULE10]

	property p_loopTxHigh;
		@(posedge sys_clk) disable iff (!nrst)
		modemCtl_q.loopback[*2] |-> txd_q;
	endproperty
	a_loopTxHigh: assert property (p_loopTxHigh) else $error("txd low in loopback"); // [RULE14]

	property p_divWrite;
		@(posedge sys_clk) disable iff (!nrst)
		acc & write & dlab & (idx == IDX_DIV_HI) |=>
			divHi_q == $past(writedata[7:0]) && txCnt_q == 17'd0;
	endproperty
	a_divWrite: assert property (p_divWrite) else $error("divisor write failed"); // [RULE18]
endmodule // ulmsd_uart
`default_nettype wire

//--- ulmsd_line_partner.sv
/*
 * far-side serial device: sends frames on the receive line, captures
 * frames from the transmit line.
 * assumes bitTime equals the divisor programmed into the port.
 */
`timescale 1ns/1ps
`default_nettype none
module ulmsd_line_partner (
	input  wire logic        sys_clk,
	input  wire logic [7:0]  bitTime,
	input  wire logic        sendGo,
	input  wire logic [11:0] sendBits,
	input  wire logic [3:0]  sendLen,
	output logic             rxd,
	input  wire logic        txd,
	input  wire logic [3:0]  capLen,
	output logic [11:0]      capBits,
	output logic [7:0]       capCount
);
	int i;
	int j;
	// sender: frame lsb first, line idles at mark
	initial begin
		rxd = 1'b1;
		forever begin
			do begin
				@(posedge sys_clk);
			end while (!sendGo);
			for (i = 0; i < sendLen; i++) begin
				rxd <= sendBits[i];
				repeat (bitTime) @(posedge sys_clk);
			end
			rxd <= 1'b1;
		end
	end
	// capture: mid-bit samples after the start edge
	initial begin
		capBits = '0;
		capCount = '0;
		forever begin
			@(negedge txd);
			repeat (bitTime / 2) @(posedge sys_clk);
			for (j = 0; j < capLen; j++) begin
				capBits[j] <= txd;
				if (j + 1 < capLen) repeat (bitTime) @(posedge sys_clk);
			end
			capCount <= capCount + 8'h01;
		end
	end
endmodule // ulmsd_line_partner
`default_nettype wire

//--- ulmsd_uart_bench.sv
/*
 * self-checking bench for the serial port status and divisor block.
 * assumes the partner model on the serial lines and bus timing per notes.
 */
`timescale 1ns/1ps
`default_nettype none
module ulmsd_uart_bench
	import ulmsd_pkg::*;
;
	localparam int BT = 4;
	logic        sys_clk, nrst, read, write, waitrequest, rxd, txd;
	logic        dcdN, riN, dsrN, ctsN, dtrN, rtsN, auxOneN, auxTwoN;
	logic [4:0]  address;
	logic [31:0] writedata, readdata;
	logic        sendGo, loopOn;
	logic [11:0] sendBits, capBits;
	logic [3:0]  sendLen;
	logic [7:0]  capCount, rdv, c0;
	int          num_errors, checks, cyc, k;

	ulmsd_uart dut (.sys_clk, .nrst, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .rxd, .txd, .dcdN, .riN, .dsrN, .ctsN,
		.dtrN, .rtsN, .auxOneN, .auxTwoN);
	ulmsd_line_partner peer (.sys_clk, .bitTime(8'(BT)), .sendGo, .sendBits,
		.sendLen, .rxd, .txd, .capLen(4'd11), .capBits, .capCount);

	////////////////////////////////////////////////////////////////////////////
	// clock, timeout, loopback line watch
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (loopOn) chk({7'h0, txd}, 8'h01);
		if (cyc == 20000) begin
			num_errors++;
			close_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// report and compare
	task close_out;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("Error t=%0t got %h want %h", $time, g, e);
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	// avalon access: hold until waitrequest low, take data at that edge
	task acc(input logic w, input logic [2:0] i, input logic [7:0] d);
		repeat (2) @(posedge sys_clk);
		address <= {i, 2'b00};
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		// no limit of its own: waitrequest low ends this wait, else the bench timeout
		do begin
			@(posedge sys_clk);
		end while (waitrequest !== 1'b0);
		rdv = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task wr(input logic [2:0] i, input logic [7:0] d);
		acc(1'b1, i, d);
	endtask
	task rc(input logic [2:0] i, input logic [7:0] m, input logic [7:0] e);
		acc(1'b0, i, 8'h00);
		chk(rdv & m, e);
	endtask
	// one frame from the partner: pm = {parity on, even}, bad flips parity
	task snd(input logic [7:0] d, input int n, input logic [1:0] pm,
		input logic bad, input logic stp);
		logic [11:0] f;
		logic [7:0]  dm;
		int          c;
		dm = d & ((8'h01 << n) - 8'h01);
		f = {3'h0, dm, 1'b0};
		c = n + 1;
		if (pm[1]) begin
			f[c] = (^dm) ^ ~pm[0] ^ bad;
			c++;
		end
		f[c] = stp;
		c++;
		sendBits <= f;
		sendLen <= 4'(c);
		sendGo <= 1'b1;
		@(posedge sys_clk);
		sendGo <= 1'b0;
		repeat (c * BT + 12) @(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		nrst = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		{dcdN, riN, dsrN, ctsN} = 4'hf;
		sendGo = 1'b0;
		sendBits = '0;
		sendLen = '0;
		loopOn = 1'b0;
		repeat (8) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rc(IDX_LINE_ST, 8'hff, 8'h60);
		// divisor bytes
		wr(IDX_LINE_CTL, 8'h83);
		rc(IDX_DIV_LO, 8'hff, 8'h00);
		rc(IDX_DIV_HI, 8'hff, 8'h00);
		wr(IDX_DIV_HI, 8'h5a);
		rc(IDX_DIV_HI, 8'hff, 8'h5a);
		wr(IDX_DIV_HI, 8'h00);
		wr(IDX_DIV_LO, 8'(BT));
		rc(IDX_DIV_LO, 8'hff, 8'(BT));
		wr(IDX_LINE_CTL, 8'h03);
		rc(3'h6, 8'hff, 8'h00);
		// modem levels, deltas, ring edge
		rc(IDX_MODEM_ST, 8'hff, 8'h00);
		{dcdN, riN, dsrN, ctsN} <= 4'h0;
		rc(IDX_MODEM_ST, 8'hff, 8'hfb);
		rc(IDX_MODEM_ST, 8'hff, 8'hf0);
		riN <= 1'b1;
		rc(IDX_MODEM_ST, 8'hff, 8'hb4);
		rc(IDX_MODEM_ST, 8'hff, 8'hb0);
		wr(IDX_MODEM_CTL, 8'h0f);
		rc(IDX_MODEM_CTL, 8'hff, 8'h0f);
		chk({4'h0, auxTwoN, auxOneN, rtsN, dtrN}, 8'h00);
		// loopback sources and internal path
		wr(IDX_MODEM_CTL, 8'h19);
		loopOn <= 1'b1;
		rc(IDX_MODEM_ST, 8'hf0, 8'ha0);
		wr(IDX_MODEM_CTL, 8'h16);
		rc(IDX_MODEM_ST, 8'hf0, 8'h50);
		wr(IDX_DIV_LO, 8'h3c);
		repeat (15 * BT) @(posedge sys_clk);
		rc(IDX_RX_DATA, 8'hff, 8'h3c);
		wr(IDX_MODEM_CTL, 8'h00);
		loopOn <= 1'b0;
		// every character length, even parity
		for (k = 0; k < 4; k++) begin
			wr(IDX_LINE_CTL, 8'h18 | 8'(k));
			snd(8'hb5, k + 5, 2'b11, 1'b0, 1'b1);
			rc(IDX_LINE_ST, 8'hff, 8'h61);
			rc(IDX_RX_DATA, 8'hff, 8'hb5 & ((8'h01 << (k + 5)) - 8'h01));
			rc(IDX_LINE_ST, 8'hff, 8'h60);
		end
		// transmit frame on the wire
		c0 = capCount;
		wr(IDX_DIV_LO, 8'ha5);
		rc(IDX_LINE_ST, 8'h40, 8'h00);
		k = 0;
		while (capCount === c0 && k < 800) begin
			@(posedge sys_clk);
			k++;
		end
		chk(capBits[8:1], 8'ha5);
		chk({5'h0, capBits[10:9], capBits[0]}, 8'h04);
		// fill the transmit fifo past full, then drain
		wr(IDX_LINE_CTL, 8'h03);
		for (k = 0; k < 10; k++) wr(IDX_DIV_LO, 8'(k));
		rc(IDX_LINE_ST, 8'h60, 8'h00);
		k = 0;
		do begin
			acc(1'b0, IDX_LINE_ST, 8'h00);
			k++;
		end while (rdv !== 8'h60 && k < 400);
		chk(rdv, 8'h60);
		// parity, framing, break
		wr(IDX_LINE_CTL, 8'h0b);
		snd(8'h5a, 8, 2'b10, 1'b1, 1'b1);
		rc(IDX_LINE_ST, 8'hff, 8'he5);
		rc(IDX_LINE_ST, 8'hff, 8'h61);
		acc(1'b0, IDX_RX_DATA, 8'h00);
		wr(IDX_LINE_CTL, 8'h03);
		snd(8'h55, 8, 2'b00, 1'b0, 1'b0);
		rc(IDX_LINE_ST, 8'hfe, 8'he8);
		snd(8'h00, 8, 2'b00, 1'b0, 1'b0);
		rc(IDX_LINE_ST, 8'h90, 8'h90);
		rc(IDX_LINE_ST, 8'h9e, 8'h00);
		repeat (3) acc(1'b0, IDX_RX_DATA, 8'h00);
		// overrun: nine characters into eight places
		for (k = 0; k < 9; k++) snd(8'(8'h11 + k), 8, 2'b00, 1'b0, 1'b1);
		rc(IDX_LINE_ST, 8'hff, 8'h63);
		for (k = 0; k < 8; k++) rc(IDX_RX_DATA, 8'hff, 8'(8'h11 + k));
		rc(IDX_LINE_ST, 8'hff, 8'h60);
		close_out;
	end
endmodule // ulmsd_uart_bench
`default_nettype wire
